// File: logic/ssa_slave.sv
// SMBus slave front end with strapped address and alert response.
`include "ssa_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RULE1] Pull ALERT low when a fault flag and its enable are both set.
// [RULE2] On alert response address, send own address, then release ALERT.
// [RULE3] Release ALERT when addressed by own address in a normal transfer.
// [RULE4] Do not realert a served fault until it clears and sets again.
// [RULE5] Byte write: address, command, one data byte, every byte acknowledged.
// [RULE6] Word write second data byte is acknowledged but discarded.
// [RULE7] Byte read: command, repeated start, address read, one register byte.
// [RULE8] If master acknowledges read byte, send the same register again.
// [RULE9] Alert response: acknowledge, send seven-bit address with trailing zero.
// [RULE10] Address is binary 10 plus five bits decoded from three tri-state straps.
// [RULE11] Accept mass-write address writes unless mass-write enable is low.
// [RULE12] Acknowledge alert response address only while holding ALERT low.
// [RULE13] Latch low three command bits into the register pointer.
// [RULE14] Drop out on lost arbitration during alert response, keep ALERT.
module ssa_slave (
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic alert_out,
  output logic alert_oe_out,
  // Address straps.
  input wire logic [1:0] addr_strap_pin_lo_in,
  input wire logic [1:0] addr_strap_pin_mid_in,
  input wire logic [1:0] addr_strap_pin_hi_in,
  // Faults and control.
  input wire logic [7:0] fault_in,
  input wire logic [7:0] alert_en_in,
  input wire logic mass_wr_en_in,
  // Register port.
  output logic [2:0] reg_ptr_out,
  input wire logic [7:0] reg_rdata_in,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out
);
  import ssa_pkg::*;

  ssa_state_s s_r;
  ssa_state_s s_nxt;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic rx_done;
  logic addr_done;
  logic [6:0] rx_addr;
  logic [6:0] own_addr;
  logic own_hit;
  logic mass_hit;
  logic ara_hit;
  logic ara_done;
  logic lost;
  logic rel;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  //////////////////////////////////////////////////////////////////////////////
  // Strap decoding.

  function automatic logic [1:0] ssa_norm(input logic [1:0] p);
    return (p == `SSA_STRAP_BAD) ? `SSA_STRAP_NC : p;
  endfunction

  function automatic logic [4:0] ssa_strap_idx(input logic [5:0] p);
    logic [1:0] h;
    logic [1:0] m;
    logic [1:0] l;
    logic [2:0] low;
    h = ssa_norm(p[5:4]);
    m = ssa_norm(p[3:2]);
    l = ssa_norm(p[1:0]);
    case ({m, l})
      {`SSA_STRAP_NC, `SSA_STRAP_L}: low = 3'h0;
      {`SSA_STRAP_H, `SSA_STRAP_NC}: low = 3'h1;
      {`SSA_STRAP_NC, `SSA_STRAP_NC}: low = 3'h2;
      {`SSA_STRAP_NC, `SSA_STRAP_H}: low = 3'h3;
      {`SSA_STRAP_L, `SSA_STRAP_L}: low = 3'h4;
      {`SSA_STRAP_H, `SSA_STRAP_H}: low = 3'h5;
      {`SSA_STRAP_L, `SSA_STRAP_NC}: low = 3'h6;
      {`SSA_STRAP_L, `SSA_STRAP_H}: low = 3'h7;
      default: low = 3'h0;
    endcase
    if (m == `SSA_STRAP_H && l == `SSA_STRAP_L) begin
      return `SSA_SPECIAL_BASE + {3'h0, h};
    end
    return {h, low};
  endfunction

  assign own_addr = {`SSA_ADDR_HI, ssa_strap_idx(s_r.strap_b)}; // RULE10

  //////////////////////////////////////////////////////////////////////////////
  // Bus events.

  assign scl = s_r.scl_sy[1];
  assign sda = s_r.sda_sy[1];
  assign rise = scl & ~s_r.scl_d;
  assign fall = ~scl & s_r.scl_d;
  assign start = scl & s_r.scl_d & s_r.sda_d & ~sda;
  assign stop = scl & s_r.scl_d & ~s_r.sda_d & sda;
  assign rx_done = (s_r.st == ST_RX) && fall && (s_r.bits == `SSA_BITS_PER_BYTE);
  assign addr_done = rx_done && (s_r.kind == K_ADDR);
  assign rx_addr = s_r.sh[7:1];
  assign own_hit = addr_done && (rx_addr == own_addr);
  assign mass_hit = addr_done && (rx_addr == `SSA_MASS_ADDR) && !s_r.sh[0] && mass_wr_en_in; // RULE11
  assign ara_hit = addr_done && (rx_addr == `SSA_ARA_ADDR) && s_r.sh[0] && s_r.alert; // RULE12
  assign ara_done = (s_r.st == ST_TACK) && rise && s_r.ara; // RULE2
  assign lost = (s_r.st == ST_TX) && rise && s_r.ara && s_r.sh[7] && !sda; // RULE14
  assign rel = own_hit | ara_done; // RULE3

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_sy = {s_r.scl_sy[0], scl_in};
    s_nxt.scl_d = s_r.scl_sy[1];
    s_nxt.sda_sy = {s_r.sda_sy[0], sda_in};
    s_nxt.sda_d = s_r.sda_sy[1];
    s_nxt.strap_a = {addr_strap_pin_hi_in, addr_strap_pin_mid_in, addr_strap_pin_lo_in};
    s_nxt.strap_b = s_r.strap_a;
    s_nxt.wr = 1'b0;
    if (stop) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else if (start) begin
      s_nxt.st = ST_RX;
      s_nxt.kind = K_ADDR;
      s_nxt.bits = 4'h0;
      s_nxt.rd = 1'b0;
      s_nxt.ara = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        ST_RX: begin
          if (rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda};
            s_nxt.bits = s_r.bits + 4'h1;
          end else if (rx_done) begin
            s_nxt.st = ST_RACK;
            s_nxt.sda_oe = 1'b1; // RULE5
            case (s_r.kind)
              K_ADDR: begin
                if (own_hit || mass_hit || ara_hit) begin
                  s_nxt.kind = K_CMD;
                  s_nxt.rd = s_r.sh[0]; // RULE7
                  s_nxt.ara = ara_hit; // RULE9
                end else begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.sda_oe = 1'b0;
                end
              end
              K_CMD: begin
                s_nxt.ptr = s_r.sh[2:0]; // RULE13
                s_nxt.kind = K_D1;
              end
              K_D1: begin
                s_nxt.wr = 1'b1;
                s_nxt.wdata = s_r.sh;
                s_nxt.kind = K_D2;
              end
              default: s_nxt.kind = K_D2; // RULE6
            endcase
          end
        end
        ST_RACK: begin
          if (fall) begin
            s_nxt.bits = 4'h0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = ST_RX;
            if (s_r.rd) begin
              s_nxt.st = ST_TX;
              s_nxt.sh = s_r.ara ? {own_addr, 1'b0} : reg_rdata_in; // RULE9
              s_nxt.sda_oe = ~s_nxt.sh[7];
            end
          end
        end
        ST_TX: begin
          if (rise) begin
            s_nxt.bits = s_r.bits + 4'h1;
            if (lost) begin
              s_nxt.st = ST_IDLE; // RULE14
              s_nxt.sda_oe = 1'b0;
            end
          end else if (fall) begin
            if (s_r.bits == `SSA_BITS_PER_BYTE) begin
              s_nxt.st = ST_TACK;
              s_nxt.sda_oe = 1'b0;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.sh[6];
            end
          end
        end
        ST_TACK: begin
          if (rise) begin
            s_nxt.mack = ~sda;
          end else if (fall) begin
            if (s_r.mack && !s_r.ara) begin
              s_nxt.st = ST_TX; // RULE8
              s_nxt.bits = 4'h0;
              s_nxt.sh = reg_rdata_in;
              s_nxt.sda_oe = ~reg_rdata_in[7];
            end else begin
              s_nxt.st = ST_IDLE;
            end
          end
        end
        default: s_nxt.st = ST_IDLE;
      endcase
    end
    s_nxt.served = (s_r.served | (rel ? fault_in : 8'h00)) & fault_in; // RULE4
    s_nxt.alert = |(fault_in & alert_en_in & ~s_nxt.served); // RULE1
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.scl_sy <= 2'h3;
      s_r.scl_d <= 1'b1;
      s_r.sda_sy <= 2'h3;
      s_r.sda_d <= 1'b1;
      s_r.strap_a <= `SSA_RESET_STRAP;
      s_r.strap_b <= `SSA_RESET_STRAP;
      s_r.st <= ST_IDLE;
      s_r.kind <= K_ADDR;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = s_r.sda_oe;
  assign alert_out = 1'b0;
  assign alert_oe_out = s_r.alert;
  assign reg_ptr_out = s_r.ptr;
  assign reg_wr_out = s_r.wr;
  assign reg_wdata_out = s_r.wdata;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_alert_set;
    ce_in && !rel && |(fault_in & alert_en_in & ~s_r.served) |=> alert_oe_out;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert not raised"); // RULE1

  property p_alert_quiet;
    ce_in && ((fault_in & alert_en_in & ~s_r.served) == 8'h00) |=> !alert_oe_out;
  endproperty
  a_alert_quiet: assert property (p_alert_quiet) else $error("alert raised without cause"); // RULE4

  property p_own_release;
    ce_in && own_hit |=> (s_r.served & $past(fault_in)) == $past(fault_in);
  endproperty
  a_own_release: assert property (p_own_release) else $error("own address did not serve faults"); // RULE3

  property p_ara_ack;
    ce_in && addr_done && !own_hit && !mass_hit && !ara_hit |=> !sda_oe_out && s_r.st == ST_IDLE;
  endproperty
  a_ara_ack: assert property (p_ara_ack) else $error("foreign address acknowledged"); // RULE12

  property p_addr_range;
    own_addr[6:5] == `SSA_ADDR_HI && own_addr[4:0] <= `SSA_ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("strapped address out of range"); // RULE10

  property p_ptr_latch;
    ce_in && rx_done && s_r.kind == K_CMD |=> reg_ptr_out == $past(s_r.sh[2:0]);
  endproperty
  a_ptr_latch: assert property (p_ptr_latch) else $error("pointer not latched"); // RULE13

  property p_one_write;
    ce_in && rx_done && s_r.kind == K_D2 |=> !reg_wr_out && sda_oe_out;
  endproperty
  a_one_write: assert property (p_one_write) else $error("second data byte written or unacked"); // RULE6

  property p_ara_load;
    s_r.st == ST_TX && $past(s_r.st) == ST_RACK && s_r.ara |-> s_r.sh == {own_addr, 1'b0};
  endproperty
  a_ara_load: assert property (p_ara_load) else $error("alert response sent wrong address"); // RULE9

  property p_lost;
    ce_in && lost && !stop |=> s_r.st == ST_IDLE && !sda_oe_out;
  endproperty
  a_lost: assert property (p_lost) else $error("no drop out on lost arbitration"); // RULE14

  property p_repeat;
    ce_in && !stop && !start && s_r.st == ST_TACK && fall && s_r.mack && !s_r.ara
      |=> s_r.st == ST_TX && s_r.sh == $past(reg_rdata_in);
  endproperty
  a_repeat: assert property (p_repeat) else $error("word read did not repeat register"); // RULE8

  c_write: cover property (reg_wr_out);
  c_ara: cover property (ce_in && ara_done);
  c_repeat: cover property (s_r.st == ST_TACK && fall && s_r.mack && !s_r.ara);
  c_lost: cover property (ce_in && lost);
endmodule

// File: logic/ssa_defines.svh
// Constants for the SMBus slave with alert addressing.
`ifndef SSA_DEFINES_SVH
`define SSA_DEFINES_SVH
`define SSA_ADDR_HI 2'h2
`define SSA_ARA_ADDR 7'h0c
`define SSA_MASS_ADDR 7'h5f
`define SSA_STRAP_L 2'h0
`define SSA_STRAP_NC 2'h1
`define SSA_STRAP_H 2'h2
`define SSA_STRAP_BAD 2'h3
`define SSA_ADDR_MAX 5'h1a
`define SSA_SPECIAL_BASE 5'h18
`define SSA_BITS_PER_BYTE 4'h8
`define SSA_RESET_STRAP 6'h15
`endif

// File: logic/ssa_pkg.sv
// Types for the SMBus slave with alert addressing.
package ssa_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RACK, ST_TX, ST_TACK} ssa_state_e;
  typedef enum logic [1:0] {K_ADDR, K_CMD, K_D1, K_D2} ssa_kind_e;
  typedef struct packed {
    logic [1:0] scl_sy;
    logic scl_d;
    logic [1:0] sda_sy;
    logic sda_d;
    logic [5:0] strap_a;
    logic [5:0] strap_b;
    ssa_state_e st;
    ssa_kind_e kind;
    logic rd;
    logic ara;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [2:0] ptr;
    logic mack;
    logic sda_oe;
    logic alert;
    logic [7:0] served;
    logic wr;
    logic [7:0] wdata;
  } ssa_state_s;
endpackage

// File: tb/ssa_master.sv
// Bus master model that clocks the bus and pulls the data line low.
module ssa_master (
  // Clock.
  input wire logic clk_in,
  // Bus pins.
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic ph(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Start or repeated start; the clock stays high while idle.
  task automatic start();
    if (busy) begin
      scl_out = 1'b0;
      sda_low_out = 1'b0;
      ph(6);
      scl_out = 1'b1;
      ph(4);
    end
    sda_low_out = 1'b1;
    ph(4);
    busy = 1'b1;
  endtask
  task automatic stop();
    scl_out = 1'b0;
    ph(2);
    sda_low_out = 1'b1;
    ph(2);
    scl_out = 1'b1;
    ph(4);
    sda_low_out = 1'b0;
    ph(4);
    busy = 1'b0;
  endtask
  // Sends b MSB first, reads the line back, then gives mack in the ninth bit.
  task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      scl_out = 1'b0;
      ph(2);
      sda_low_out = ~b[i];
      ph(2);
      scl_out = 1'b1;
      ph(4);
      r[i] = sda_in;
    end
    scl_out = 1'b0;
    ph(2);
    sda_low_out = mack;
    ph(2);
    scl_out = 1'b1;
    ph(4);
    ack = ~sda_in;
  endtask
endmodule

// File: tb/ssa_slave_test.sv
// Self-checking bench for the SMBus slave with alert addressing.
module ssa_slave_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, scl, sda, sda_low, sda_oe, alert_oe, reg_wr, mass_en, k;
  logic ce, sda_o, alert_o, alert_n;
  logic [1:0] strap_lo, strap_mid, strap_hi;
  logic [7:0] fault, en, rdata, wdata, r;
  logic [2:0] ptr;
  int error_cnt = 0;
  int tests_run = 0;
  int wr_cnt = 0;
  // Pull-up on the data line.
  assign sda = ~sda_low & (~sda_oe | sda_o);
  // Pull-up on the alert line.
  assign alert_n = ~alert_oe | alert_o;
  always @(negedge clk) rdata <= {5'h15, ptr};
  always @(posedge clk) if (reg_wr === 1'b1) wr_cnt++;
  ssa_slave DUT (
    .clk_in(clk), .rst_in(rst), .ce_in(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .alert_out(alert_o), .alert_oe_out(alert_oe), .addr_strap_pin_lo_in(strap_lo),
    .addr_strap_pin_mid_in(strap_mid), .addr_strap_pin_hi_in(strap_hi), .fault_in(fault), .alert_en_in(en),
    .mass_wr_en_in(mass_en), .reg_ptr_out(ptr), .reg_rdata_in(rdata), .reg_wr_out(reg_wr),
    .reg_wdata_out(wdata)
  );
  ssa_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic a);
    m.xfer(b, 1'b0, r, k);
    check({7'h0, k}, {7'h0, a});
  endtask
  task automatic rb(input logic mack, input logic [7:0] exp);
    m.xfer(8'hff, mack, r, k);
    check(r, exp);
  endtask
  task automatic final_report();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    strap_lo = 2'h2;
    strap_mid = 2'h1;
    strap_hi = 2'h2;
    fault = 8'h00;
    en = 8'h00;
    mass_en = 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (8) @(negedge clk);
    // Word write: only the first data byte lands.
    m.start();
    wb(8'ha6, 1'b1);
    wb(8'h2d, 1'b1);
    wb(8'h3c, 1'b1);
    wb(8'h99, 1'b1);
    m.stop();
    check({5'h0, ptr}, 8'h05);
    check(wdata, 8'h3c);
    check(wr_cnt[7:0], 8'h01);
    // Word read: the same register comes twice.
    m.start();
    wb(8'ha6, 1'b1);
    wb(8'h03, 1'b1);
    m.start();
    wb(8'ha7, 1'b1);
    rb(1'b1, 8'hab);
    rb(1'b0, 8'hab);
    m.stop();
    // A fault without its enable raises no alert, and the alert response address gets no acknowledge.
    fault = 8'h04;
    repeat (4) @(negedge clk);
    check({7'h0, alert_oe}, 8'h00);
    m.start();
    wb(8'h19, 1'b0);
    m.stop();
    // A low clock enable freezes the alert until it returns.
    ce = 1'b0;
    en = 8'h04;
    repeat (4) @(negedge clk);
    check({7'h0, alert_oe}, 8'h00);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h0, alert_oe}, 8'h01);
    check({7'h0, alert_n}, 8'h00);
    m.start();
    wb(8'h19, 1'b1);
    m.xfer(8'h00, 1'b0, r, k);
    m.stop();
    check({7'h0, alert_oe}, 8'h01);
    m.start();
    wb(8'h19, 1'b1);
    rb(1'b0, 8'ha6);
    m.stop();
    check({7'h0, alert_oe}, 8'h00);
    repeat (8) @(negedge clk);
    check({7'h0, alert_oe}, 8'h00);
    fault = 8'h00;
    repeat (4) @(negedge clk);
    fault = 8'h04;
    repeat (4) @(negedge clk);
    check({7'h0, alert_oe}, 8'h01);
    m.start();
    wb(8'ha6, 1'b1);
    wb(8'h00, 1'b1);
    m.stop();
    check({7'h0, alert_oe}, 8'h00);
    // Mass write disabled, then enabled; a foreign address is ignored.
    mass_en = 1'b0;
    m.start();
    wb(8'hbe, 1'b0);
    m.stop();
    mass_en = 1'b1;
    m.start();
    wb(8'hbe, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h55, 1'b1);
    m.stop();
    check(wdata, 8'h55);
    check(wr_cnt[7:0], 8'h02);
    check({5'h0, ptr}, 8'h01);
    m.start();
    wb(8'h90, 1'b0);
    m.stop();
    // Special strapping with code 3 read as open moves the address.
    strap_lo = 2'h0;
    strap_mid = 2'h2;
    strap_hi = 2'h3;
    repeat (4) @(negedge clk);
    m.start();
    wb(8'hb2, 1'b1);
    m.stop();
    m.start();
    wb(8'ha6, 1'b0);
    m.stop();
    final_report();
  end
endmodule
